// ===== rtl/csr_pkg.sv
package csr_pkg;
    // Register offsets (byte-wide registers on a plain address port)
    localparam logic [7:0] ADDR_CLOCK_SOURCE_CONTROL = 8'h1d;
    localparam logic [7:0] ADDR_FAULT_STATUS         = 8'h1e;
    localparam logic [7:0] ADDR_REVISION_CODE        = 8'h1f;
    localparam logic [7:0] ADDR_RX_EVENT             = 8'h20;
    localparam logic [7:0] ADDR_RX_CONFIG            = 8'h21;
    localparam logic [7:0] ADDR_CHANNEL_A_IO_CONFIG  = 8'h1a;
    localparam logic [7:0] ADDR_CHANNEL_B_IO_CONFIG  = 8'h1b;
    localparam logic [7:0] ADDR_RECEIVE_FIFO_A       = 8'h22;
    localparam logic [7:0] ADDR_RECEIVE_FIFO_B       = 8'h23;
    // Clock-source control fields
    localparam int CLK_SUPPLY_WARN_IRQ_EN = 7;
    localparam int CLK_PIN_DRIVE_OVERRIDE = 6;
    localparam int CLK_CLOCK_OUTPUT_EN    = 4;
    localparam int CLK_DIV_HI             = 3;
    localparam int CLK_DIV_LO             = 2;
    localparam int CLK_EXTERNAL_SEL       = 1;
    localparam int CLK_CRYSTAL_EN         = 0;
    localparam logic [7:0] CLK_WRITE_MASK = 8'hdf;
    // Fault status fields: latched copies sit 4 above their live flags
    localparam int STAT_LATCH_LO = 4;
    localparam int STAT_SUPPLY_WARN = 0;
    // Channel io config fields
    localparam int IO_TX_EN = 5;
    localparam int IO_TX    = 4;
    // Receive event / config fields (channel a bit 0, channel b bit 1)
    localparam int RX_READY_LO = 0;
    localparam int RX_ERROR_LO = 2;
    localparam int RXCFG_READY_PIN_EN = 0;
    localparam int RXCFG_ERROR_PIN_EN = 1;
    localparam int RXCFG_RETRANSMIT   = 2;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Revision code: arbitrary neutral value
    localparam logic [3:0] REVISION_CODE_BITS = 4'h3;
    // Clock output 3.686 MHz derived from the 14.745 MHz reference (div 4)
    localparam int CLKOUT_HALF_PERIOD = 2;
endpackage : csr_pkg

// ===== rtl/csr_if.sv
`timescale 1ns/100ps
interface csr_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata);
endinterface : csr_if

// ===== rtl/csr_device.sv
`timescale 1ns/100ps
module csr_device (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Register port
    csr_if.dev              bus,
    // Analog monitor indications (asynchronous)
    input  wire logic       thermal_shutdown_in,
    input  wire logic       temp_above_warn_in,
    input  wire logic       temp_below_clear_in,
    input  wire logic       supply_undervoltage_in,
    input  wire logic       supply_warning_in,
    // Line control pins (asynchronous), channel a bit 0
    input  wire logic [1:0] transmit_pin,
    input  wire logic [1:0] transmit_enable_pin,
    // Framer events, one-cycle pulses
    input  wire logic [1:0] rx_message_good,
    input  wire logic [1:0] rx_message_bad,
    // Outputs
    output logic [1:0]      line_out,
    output logic [1:0]      line_drive_en,
    output logic            clock_output_pin,
    output logic            crystal_osc_enable,
    output logic            external_clock_select,
    output logic [1:0]      crystal_divider_select,
    output logic            status_interrupt,
    output logic            irq_n,
    output logic [1:0]      receive_ready_pin_n,
    output logic [1:0]      receive_error_pin_n,
    output logic [1:0]      retransmit_req
);
    logic [7:0] clk_ctl_r;
    logic [7:0] io_a_r;
    logic [7:0] io_b_r;
    logic [7:0] rx_cfg_r;
    logic [3:0] live_r;
    logic [3:0] live_prev_r;
    logic [3:0] latched_r;
    logic [1:0] rx_ready_r;
    logic [1:0] rx_error_r;
    logic [4:0] mon_s1_r;
    logic [4:0] mon_s2_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [1:0] clk_div_r;
    logic [7:0] rdata_r;
    logic       rd_status;
    logic       rd_fifo_a;
    logic       rd_fifo_b;
    logic [3:0] rise;
    logic       live_temp_nxt;

    assign rd_status = bus.rd && bus.addr == csr_pkg::ADDR_FAULT_STATUS;
    assign rd_fifo_a = bus.rd && bus.addr == csr_pkg::ADDR_RECEIVE_FIFO_A;
    assign rd_fifo_b = bus.rd && bus.addr == csr_pkg::ADDR_RECEIVE_FIFO_B;
    assign bus.rdata = rdata_r;

    // Two-stage synchronisers for monitors and pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mon_s1_r <= '0;
            mon_s2_r <= '0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            mon_s1_r <= {thermal_shutdown_in, temp_above_warn_in,
                         temp_below_clear_in, supply_undervoltage_in,
                         supply_warning_in};
            mon_s2_r <= mon_s1_r;
            pin_s1_r <= {transmit_enable_pin, transmit_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Writable registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_ctl_r <= csr_pkg::RESET_VALUE;
            io_a_r    <= csr_pkg::RESET_VALUE;
            io_b_r    <= csr_pkg::RESET_VALUE;
            rx_cfg_r  <= csr_pkg::RESET_VALUE;
        end else if (bus.wr) begin
            case (bus.addr)
                csr_pkg::ADDR_CLOCK_SOURCE_CONTROL:
                    clk_ctl_r <= bus.wdata & csr_pkg::CLK_WRITE_MASK;
                csr_pkg::ADDR_CHANNEL_A_IO_CONFIG: io_a_r <= bus.wdata;
                csr_pkg::ADDR_CHANNEL_B_IO_CONFIG: io_b_r <= bus.wdata;
                csr_pkg::ADDR_RX_CONFIG:           rx_cfg_r <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Live flags; temperature warning has hysteresis
    always_comb begin
        live_temp_nxt = live_r[2];
        if (mon_s2_r[3]) begin
            live_temp_nxt = 1'b1;
        end else if (mon_s2_r[2]) begin
            live_temp_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            live_r      <= '0;
            live_prev_r <= '0;
        end else begin
            live_r[3]   <= mon_s2_r[4];
            live_r[2]   <= live_temp_nxt;
            live_r[1]   <= mon_s2_r[1];
            live_r[0]   <= mon_s2_r[0];
            live_prev_r <= live_r;
        end
    end

    assign rise = live_r & ~live_prev_r;

    // Latched copies: a rising flag in the read cycle is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latched_r <= '0;
        end else begin
            latched_r <= (rd_status ? 4'h0 : latched_r) | rise;
        end
    end

    // Receive events, set wins over the clearing read (fifo read for ready, event read for error)
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_ready_r <= '0;
            rx_error_r <= '0;
        end else begin
            rx_ready_r <= (rx_ready_r & ~{rd_fifo_b, rd_fifo_a})
                          | rx_message_good;
            if (bus.rd && bus.addr == csr_pkg::ADDR_RX_EVENT) begin
                rx_error_r <= rx_message_bad;
            end else begin
                rx_error_r <= rx_error_r | rx_message_bad;
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                csr_pkg::ADDR_CLOCK_SOURCE_CONTROL: rdata_r <= clk_ctl_r;
                csr_pkg::ADDR_FAULT_STATUS: rdata_r <= {latched_r, live_r};
                csr_pkg::ADDR_REVISION_CODE:
                    rdata_r <= {4'h0, csr_pkg::REVISION_CODE_BITS};
                csr_pkg::ADDR_CHANNEL_A_IO_CONFIG: rdata_r <= io_a_r;
                csr_pkg::ADDR_CHANNEL_B_IO_CONFIG: rdata_r <= io_b_r;
                csr_pkg::ADDR_RX_CONFIG: rdata_r <= rx_cfg_r;
                csr_pkg::ADDR_RX_EVENT:
                    rdata_r <= {4'h0, rx_error_r, rx_ready_r};
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    // Clock output: divide by four, held low when disabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_div_r        <= '0;
            clock_output_pin <= 1'b0;
        end else if (clk_ctl_r[csr_pkg::CLK_CLOCK_OUTPUT_EN]) begin
            clk_div_r <= clk_div_r + 2'd1;
            if (clk_div_r == 2'(csr_pkg::CLKOUT_HALF_PERIOD - 1)) begin
                clk_div_r        <= '0;
                clock_output_pin <= ~clock_output_pin;
            end
        end else begin
            clk_div_r        <= '0;
            clock_output_pin <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_out               <= '0;
            line_drive_en          <= '0;
            crystal_osc_enable     <= 1'b0;
            external_clock_select  <= 1'b0;
            crystal_divider_select <= '0;
            status_interrupt       <= 1'b0;
            irq_n                  <= 1'b1;
            receive_ready_pin_n    <= 2'b11;
            receive_error_pin_n    <= 2'b11;
            retransmit_req         <= '0;
        end else begin
            if (clk_ctl_r[csr_pkg::CLK_PIN_DRIVE_OVERRIDE]) begin
                line_out      <= {io_b_r[csr_pkg::IO_TX],
                                  io_a_r[csr_pkg::IO_TX]};
                line_drive_en <= {io_b_r[csr_pkg::IO_TX_EN],
                                  io_a_r[csr_pkg::IO_TX_EN]};
            end else begin
                line_out      <= pin_s2_r[1:0];
                line_drive_en <= pin_s2_r[3:2];
            end
            crystal_osc_enable <= clk_ctl_r[csr_pkg::CLK_CRYSTAL_EN];
            external_clock_select <=
                clk_ctl_r[csr_pkg::CLK_EXTERNAL_SEL];
            crystal_divider_select <=
                clk_ctl_r[csr_pkg::CLK_DIV_HI:csr_pkg::CLK_DIV_LO];
            status_interrupt <= (|latched_r[3:1])
                || (latched_r[0]
                    && clk_ctl_r[csr_pkg::CLK_SUPPLY_WARN_IRQ_EN]);
            irq_n <= ~((|rx_ready_r) || (|rx_error_r));
            receive_ready_pin_n <= ~(rx_ready_r
                & {2{rx_cfg_r[csr_pkg::RXCFG_READY_PIN_EN]}});
            receive_error_pin_n <= ~(rx_error_r
                & {2{rx_cfg_r[csr_pkg::RXCFG_ERROR_PIN_EN]}});
            retransmit_req <= rx_message_bad
                & {2{rx_cfg_r[csr_pkg::RXCFG_RETRANSMIT]}};
        end
    end
endmodule : csr_device

// ===== rtl/csr_host.sv
`timescale 1ns/100ps
module csr_host (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // User command port
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    output logic [7:0]      cmd_rdata,
    output logic            cmd_rvalid,
    // Register port
    csr_if.host             bus
);
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic       wr_r;
    logic       rd_r;
    logic       rd_wait_r;

    assign bus.addr  = addr_r;
    assign bus.wdata = wdata_r;
    assign bus.wr    = wr_r;
    assign bus.rd    = rd_r;

    // Forward one command a cycle; write wins if both asked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_r  <= '0;
            wdata_r <= '0;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
        end else begin
            addr_r  <= cmd_addr;
            wdata_r <= cmd_wdata;
            // Both clock sources on together is never sent
            if (cmd_wr && cmd_addr == csr_pkg::ADDR_CLOCK_SOURCE_CONTROL
                && cmd_wdata[csr_pkg::CLK_CRYSTAL_EN]
                && cmd_wdata[csr_pkg::CLK_EXTERNAL_SEL]) begin
                wdata_r[csr_pkg::CLK_EXTERNAL_SEL] <= 1'b0;
            end
            wr_r <= cmd_wr;
            rd_r <= cmd_rd && !cmd_wr;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_wait_r  <= 1'b0;
            cmd_rvalid <= 1'b0;
            cmd_rdata  <= '0;
        end else begin
            rd_wait_r  <= rd_r;
            cmd_rvalid <= rd_wait_r;
            cmd_rdata  <= rd_wait_r ? bus.rdata : cmd_rdata;
        end
    end
endmodule : csr_host

// ===== testbench/csr_chk.sv
`timescale 1ns/100ps
module csr_chk (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    wire c_wr = wr && addr == 8'h1d;
    wire c_rd = rd && addr == 8'h1d;
    wire s_rd = rd && addr == 8'h1e;
    wire v_rd = rd && addr == 8'h1f;
    wire i_wr = wr && addr == 8'h1a;
    wire i_rd = rd && addr == 8'h1a;
    wire unmap = addr < 8'h1a || addr > 8'h23 || addr == 8'h1c;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    chk_one_strobe: assert property (!(wr && rd))
        else $error("strobes together");
    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside answer cycle");
    chk_rev_code: assert property (
        v_rd |=> rdata == {4'h0, csr_pkg::REVISION_CODE_BITS})
        else $error("revision code wrong");
    chk_stat_clear: assert property (
        s_rd ##1 s_rd |=> (rdata[7:4] & ~rdata[3:0]) == 4'h0)
        else $error("latched bits survive read");
    chk_unmapped_zero: assert property (rd && unmap |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_clk_bit5: assert property (c_rd |=> !rdata[5])
        else $error("unused clock bit set");
    chk_clk_readback: assert property (
        c_wr ##1 c_rd |=> rdata == ($past(wdata, 2) & 8'hdf))
        else $error("clock register readback");
    chk_io_readback: assert property (
        i_wr ##1 i_rd |=> rdata[5:4] == $past(wdata[5:4], 2))
        else $error("line control bits readback");
    chk_xtal_excl: assert property (c_wr |-> !(wdata[1] && wdata[0]))
        else $error("both clock sources written");
    cover property (s_rd ##1 s_rd);
    cover property (c_wr ##1 c_rd);
    cover property (v_rd);
endmodule : csr_chk

// ===== testbench/clock_status_revision_regs_bench.sv
`timescale 1ns/100ps
module clock_status_revision_regs_bench;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, rdata;
    logic       cmd_wr = 1'b0, cmd_rd = 1'b0, rvalid;
    logic [4:0] mon = 5'h00;
    logic [1:0] tx_pin = 2'b00, transmit_enable_pin_pin = 2'b00, good = 2'b00, bad = 2'b00;
    logic [1:0] line_out, drive_en, div_sel, rdy_n, err_n, retx;
    logic       clk_out, xtal_en, ext_sel, stat_irq, irq_n;
    int         num_errors = 0;
    int         compares = 0;
    always #20 clk = ~clk;
    csr_if bus_if ();
    csr_device csr_device_inst (.clk(clk), .resetn(resetn), .bus(bus_if.dev),
        .thermal_shutdown_in(mon[3]), .temp_above_warn_in(mon[2]),
        .temp_below_clear_in(mon[4]), .supply_undervoltage_in(mon[1]),
        .supply_warning_in(mon[0]), .transmit_pin(tx_pin),
        .transmit_enable_pin(transmit_enable_pin_pin), .rx_message_good(good),
        .rx_message_bad(bad), .line_out(line_out), .line_drive_en(drive_en),
        .clock_output_pin(clk_out), .crystal_osc_enable(xtal_en),
        .external_clock_select(ext_sel), .crystal_divider_select(div_sel),
        .status_interrupt(stat_irq), .irq_n(irq_n),
        .receive_ready_pin_n(rdy_n), .receive_error_pin_n(err_n),
        .retransmit_req(retx));
    csr_host csr_host_inst (.clk(clk), .resetn(resetn), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_rdata(rdata), .cmd_rvalid(rvalid), .bus(bus_if.host));
    csr_chk csr_chk_inst (.clk(clk), .resetn(resetn), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
        .rdata(bus_if.rdata));
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [7:0] g, e);
        compares++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
    endtask : wr
    // Bounded wait on the host's answer pulse; a lost answer ends the run
    task automatic collect(input string nm, input int n,
                           input logic [7:0] m, e1, e2);
        logic [7:0] g [2];
        int         k;
        k = 0;
        for (int i = 0; i < 8 && k < n; i++) begin
            @(negedge clk);
            if (rvalid === 1'b1) begin
                g[k] = rdata;
                k++;
            end
        end
        if (k < n) begin
            $display("[FAIL] %s expected answer seen none", nm);
            num_errors++;
            wrap_up();
        end else begin
            chk(nm, g[0] & m, e1);
            if (n == 2) begin
                chk(nm, g[1] & m, e2);
            end
        end
    endtask : collect
    task automatic rd(input string nm, input logic [7:0] a, input int n,
                      input logic [7:0] e1, e2);
        @(posedge clk);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        repeat (n) @(posedge clk);
        cmd_rd <= 1'b0;
        collect(nm, n, 8'hff, e1, e2);
    endtask : rd
    // Read in the cycle right after the write, so the checker sees the pair
    task automatic wr_rd(input string nm, input logic [7:0] a, d, m, e);
        @(posedge clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b1;
        @(posedge clk);
        cmd_rd <= 1'b0;
        collect(nm, 1, m, e, 8'h00);
    endtask : wr_rd
    task automatic ticks(output logic [7:0] n);
        n = 8'h00;
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            n = n + {7'h00, clk_out};
        end
    endtask : ticks
    task automatic pulse(input logic [1:0] gv, bv);
        @(posedge clk);
        good <= gv;
        bad <= bv;
        @(posedge clk);
        good <= 2'b00;
        bad <= 2'b00;
    endtask : pulse
    task automatic t_reset();
        logic [7:0] rev;
        rev = {4'h0, csr_pkg::REVISION_CODE_BITS};
        rd("clk reset", 8'h1d, 1, 8'h00, 8'h00);
        rd("stat reset", 8'h1e, 1, 8'h00, 8'h00);
        rd("rev", 8'h1f, 1, rev, 8'h00);
        wr(8'h1f, 8'hff);
        rd("rev ro", 8'h1f, 1, rev, 8'h00);
        rd("unmapped", 8'h40, 1, 8'h00, 8'h00);
    endtask : t_reset
    task automatic t_clock();
        logic [7:0] n;
        wr_rd("clk rb", 8'h1d, 8'hff, 8'hff, 8'hdd);
        chk("xtal ext", {6'h00, xtal_en, ext_sel}, 8'h02);
        ticks(n);
        chk("clk out", n, 8'h08);
        for (int d = 0; d < 4; d++) begin
            wr(8'h1d, 8'(d * 4));
            cyc(3);
            chk("divider", {6'h00, div_sel}, 8'(d));
        end
        ticks(n);
        chk("clk off", n, 8'h00);
        wr(8'h1d, 8'h02);
        cyc(3);
        chk("ext only", {6'h00, xtal_en, ext_sel}, 8'h01);
    endtask : t_clock
    task automatic t_lines();
        @(posedge clk);
        tx_pin <= 2'b01;
        transmit_enable_pin_pin <= 2'b10;
        wr_rd("io a", 8'h1a, 8'h20, 8'h30, 8'h20);
        wr_rd("io b", 8'h1b, 8'h10, 8'h30, 8'h10);
        cyc(6);
        chk("pins", {4'h0, line_out, drive_en}, 8'h06);
        wr(8'h1d, 8'h40);
        cyc(6);
        chk("regs", {4'h0, line_out, drive_en}, 8'h09);
        wr(8'h1d, 8'h00);
    endtask : t_lines
    task automatic t_status();
        logic [7:0] lv;
        wr(8'h1d, 8'h80);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            mon <= mon | (5'h01 << i);
            cyc(8);
            chk("irq set", {7'h00, stat_irq}, 8'h01);
            @(posedge clk);
            mon <= mon & ~(5'h01 << i);
            cyc(8);
            // Temperature warning stays live until the low indication
            lv = (i >= 2) ? 8'h04 : 8'h00;
            rd("stat", 8'h1e, 2, (8'h10 << i) | lv, lv);
            chk("irq clr", {7'h00, stat_irq}, 8'h00);
        end
        @(posedge clk);
        mon <= 5'h10;
        cyc(8);
        rd("warn clr", 8'h1e, 1, 8'h00, 8'h00);
        wr(8'h1d, 8'h00);
        @(posedge clk);
        mon <= 5'h01;
        cyc(8);
        chk("irq mask", {7'h00, stat_irq}, 8'h00);
        rd("warn live", 8'h1e, 1, 8'h11, 8'h00);
    endtask : t_status
    task automatic t_rx();
        logic [7:0] n;
        wr(8'h21, 8'h03);
        pulse(2'b01, 2'b00);
        cyc(4);
        chk("ready", {5'h00, irq_n, rdy_n}, 8'h02);
        rd("rx ev", 8'h20, 1, 8'h01, 8'h00);
        rd("fifo a", 8'h22, 1, 8'h00, 8'h00);
        cyc(2);
        chk("ready off", {5'h00, irq_n, rdy_n}, 8'h07);
        wr(8'h21, 8'h07);
        pulse(2'b00, 2'b10);
        n = 8'h00;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            n = n + {7'h00, retx[1]};
        end
        chk("retx", n, 8'h01);
        chk("error", {5'h00, irq_n, err_n}, 8'h01);
        rd("rx err", 8'h20, 1, 8'h08, 8'h00);
    endtask : t_rx
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_clock();
        t_lines();
        t_status();
        t_rx();
        wrap_up();
    end
endmodule : clock_status_revision_regs_bench
